// ### design/artpwm_consts.vh
`ifndef ARTPWM_CONSTS_VH
`define ARTPWM_CONSTS_VH

// Register indices (byte address = 4 * index)
`define ARTPWM_IDX_TCS      8'h0d
`define ARTPWM_IDX_CNTH     8'h0e
`define ARTPWM_IDX_CNTL     8'h0f
`define ARTPWM_IDX_RLDH     8'h10
`define ARTPWM_IDX_RLDL     8'h11
`define ARTPWM_IDX_POC      8'h12
`define ARTPWM_IDX_PCS      8'h13
`define ARTPWM_IDX_DUTH     8'h17
`define ARTPWM_IDX_DUTL     8'h18
`define ARTPWM_IDX_PWRMODE  8'h1f

// Field positions
`define ARTPWM_TCS_CKSEL_HI 4
`define ARTPWM_TCS_CKSEL_LO 3
`define ARTPWM_TCS_OVF      2
`define ARTPWM_TCS_OVERFLOW_IRQ_ENABLE    1
`define ARTPWM_TCS_COMPARE_IRQ_ENABLE    0
`define ARTPWM_PCS_POL      1
`define ARTPWM_PCS_CMPF     0
`define ARTPWM_POC_PINEN    0

// Clock selections
`define ARTPWM_CK_OFF       2'b00
`define ARTPWM_CK_TBASE     2'b01
`define ARTPWM_CK_CPU       2'b10

// Power modes
`define ARTPWM_PM_RUN       2'b00
`define ARTPWM_PM_WAIT      2'b01
`define ARTPWM_PM_AHALT     2'b10
`define ARTPWM_PM_HALT      2'b11

// Reset values and counts
`define ARTPWM_RST_BYTE     8'h00
`define ARTPWM_RST_12       12'h000
`define ARTPWM_CNT_MAX      12'hfff
`define ARTPWM_SLOW_DIV     5'h1f

`endif

// ### design/artpwm_timer.v
// Behaviour
// - 12-bit counter steps on selected clock tick
// - Overflow past all-ones loads reload value
// - Reset clears counter, reload, duty, control
// - PWM overflow loads shadow, output high
// - PWM output low at shadow match
// - Polarity bit inverts the waveform
// - Pin enable selects PWM, else compare
// - Upper duty write locks compare until lower
// - Every overflow copies duty into shadow
// - PWM compares shadow, compare mode duty
// - Compare mode uses new duty at once
// - Match sets compare flag, gated interrupt
// - No compare-mode match while duty is zero
// - Clock select field bits four to three
// - Overflow flag set, cleared by status read
// - Overflow flag held one counter cycle
// - Two separately gated interrupt outputs
// - Slow divides by 32, halt stops
// - Active-halt runs only timebase with irq
// - Wake rules for wait and active-halt
// - PWM status read clears compare flag
// - Pin released when pin enable clear
`timescale 1ns/1ps
`include "artpwm_consts.vh"

module artpwm_timer (
    input  wire        clk_sys_in,
    input  wire        rst_n_in,
    input  wire        clk_en_in,
    input  wire        tbase_tick_in,
    input  wire [7:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    output reg         pwm_output_out,
    output reg         pwm_oe_out,
    output reg         ovf_irq_out,
    output reg         cmp_irq_out,
    output reg         wake_wait_out,
    output reg         wake_ahalt_out
);

    reg  [11:0] count_value;
    reg  [11:0] reload_value;
    reg  [11:0] duty_value;
    reg  [11:0] shadow_duty;
    reg  [1:0]  counter_clock_select;
    reg         overflow_flag;
    reg         overflow_irq_enable;
    reg         compare_irq_enable;
    reg         compare_flag;
    reg         polarity_invert;
    reg         pwm_pin_enable;
    reg         cmp_locked;
    reg         pwm_raw;
    reg         ovf_hold;
    reg         slow_mode;
    reg  [1:0]  power_mode;
    reg  [4:0]  slow_cnt;
    reg         tb_meta;
    reg         tb_sync;
    reg         tb_prev;
    reg         bus_done;
    reg  [7:0]  next_rdata;

    wire [7:0]  reg_idx     = {2'b00, avs_address_in[7:2]};
    wire        wr_lane0    = avs_write_in & avs_byteenable_in[0] & ~bus_done;
    wire        rd_req      = avs_read_in & ~bus_done;
    wire        tb_edge     = tb_sync & ~tb_prev;
    wire        raw_tick    = (counter_clock_select == `ARTPWM_CK_TBASE) ? tb_edge :
                              (counter_clock_select == `ARTPWM_CK_CPU);
    wire        slow_ok     = ~slow_mode | (slow_cnt == `ARTPWM_SLOW_DIV);
    wire        ahalt_run   = (counter_clock_select == `ARTPWM_CK_TBASE) & overflow_irq_enable;
    wire        mode_run    = (power_mode == `ARTPWM_PM_RUN) | (power_mode == `ARTPWM_PM_WAIT) |
                              ((power_mode == `ARTPWM_PM_AHALT) & ahalt_run);
    wire        tick        = raw_tick & slow_ok & mode_run;
    wire        overflow    = tick & (count_value == `ARTPWM_CNT_MAX);
    wire [11:0] cmp_ref     = pwm_pin_enable ? shadow_duty : duty_value;
    wire        cmp_match   = tick & ~cmp_locked & (count_value == cmp_ref) &
                              (pwm_pin_enable | (duty_value != `ARTPWM_RST_12));
    wire        tcs_rd      = rd_req & (reg_idx == `ARTPWM_IDX_TCS);
    wire        pcs_rd      = rd_req & (reg_idx == `ARTPWM_IDX_PCS);

    always @* begin
        next_rdata = `ARTPWM_RST_BYTE;
        case (reg_idx)
            `ARTPWM_IDX_TCS:  next_rdata = {3'h0, counter_clock_select, overflow_flag,
                                            overflow_irq_enable, compare_irq_enable};
            `ARTPWM_IDX_CNTH: next_rdata = {4'h0, count_value[11:8]};
            `ARTPWM_IDX_CNTL: next_rdata = count_value[7:0];
            `ARTPWM_IDX_RLDH: next_rdata = {4'h0, reload_value[11:8]};
            `ARTPWM_IDX_RLDL: next_rdata = reload_value[7:0];
            `ARTPWM_IDX_POC:  next_rdata = {7'h00, pwm_pin_enable};
            `ARTPWM_IDX_PCS:  next_rdata = {6'h00, polarity_invert, compare_flag};
            `ARTPWM_IDX_DUTH: next_rdata = {4'h0, duty_value[11:8]};
            `ARTPWM_IDX_DUTL: next_rdata = duty_value[7:0];
            `ARTPWM_IDX_PWRMODE: next_rdata = {5'h00, slow_mode, power_mode};
            default:          next_rdata = `ARTPWM_RST_BYTE;
        endcase
    end

    // Bus slave: one wait cycle, answer on second edge
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
            bus_done            <= 1'b0;
        end else if (clk_en_in) begin
            if ((avs_read_in | avs_write_in) & ~bus_done) begin
                bus_done            <= 1'b1;
                avs_waitrequest_out <= 1'b0;
                avs_readdata_out    <= {24'h000000, next_rdata};
            end else begin
                bus_done            <= 1'b0;
                avs_waitrequest_out <= 1'b1;
            end
        end
    end

    // Timebase synchroniser and slow prescaler
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tb_meta  <= 1'b0;
            tb_sync  <= 1'b0;
            tb_prev  <= 1'b0;
            slow_cnt <= 5'h00;
        end else if (clk_en_in) begin
            tb_meta <= tbase_tick_in;
            tb_sync <= tb_meta;
            tb_prev <= tb_sync;
            if (raw_tick & mode_run) begin
                slow_cnt <= slow_cnt + 5'h01;
            end
        end
    end

    // Control registers written by software
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            counter_clock_select <= `ARTPWM_CK_OFF;
            overflow_irq_enable  <= 1'b0;
            compare_irq_enable   <= 1'b0;
            reload_value         <= `ARTPWM_RST_12;
            duty_value           <= `ARTPWM_RST_12;
            pwm_pin_enable       <= 1'b0;
            polarity_invert      <= 1'b0;
            cmp_locked           <= 1'b0;
            slow_mode            <= 1'b0;
            power_mode           <= `ARTPWM_PM_RUN;
        end else if (clk_en_in && wr_lane0) begin
            case (reg_idx)
                `ARTPWM_IDX_TCS: begin
                    counter_clock_select <= avs_writedata_in[`ARTPWM_TCS_CKSEL_HI:`ARTPWM_TCS_CKSEL_LO];
                    overflow_irq_enable  <= avs_writedata_in[`ARTPWM_TCS_OVERFLOW_IRQ_ENABLE];
                    compare_irq_enable   <= avs_writedata_in[`ARTPWM_TCS_COMPARE_IRQ_ENABLE];
                end
                `ARTPWM_IDX_RLDH: reload_value[11:8] <= avs_writedata_in[3:0];
                `ARTPWM_IDX_RLDL: reload_value[7:0]  <= avs_writedata_in[7:0];
                `ARTPWM_IDX_POC:  pwm_pin_enable     <= avs_writedata_in[`ARTPWM_POC_PINEN];
                `ARTPWM_IDX_PCS:  polarity_invert    <= avs_writedata_in[`ARTPWM_PCS_POL];
                `ARTPWM_IDX_DUTH: begin
                    duty_value[11:8] <= avs_writedata_in[3:0];
                    cmp_locked       <= 1'b1;
                end
                `ARTPWM_IDX_DUTL: begin
                    duty_value[7:0] <= avs_writedata_in[7:0];
                    cmp_locked      <= 1'b0;
                end
                `ARTPWM_IDX_PWRMODE: begin
                    power_mode <= avs_writedata_in[1:0];
                    slow_mode  <= avs_writedata_in[2];
                end
                default: power_mode <= power_mode;
            endcase
        end
    end

    // Counter, shadow and waveform
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_value <= `ARTPWM_RST_12;
            shadow_duty <= `ARTPWM_RST_12;
            pwm_raw     <= 1'b0;
        end else if (clk_en_in) begin
            if (overflow) begin
                count_value <= reload_value;
                shadow_duty <= duty_value;
                if (pwm_pin_enable) begin
                    pwm_raw <= 1'b1;
                end
            end else if (tick) begin
                count_value <= count_value + 12'h001;
                if (cmp_match & pwm_pin_enable) begin
                    pwm_raw <= 1'b0;
                end
            end
            if (!pwm_pin_enable) begin
                pwm_raw <= 1'b0;
            end
        end
    end

    // Flags: hardware set wins over read clear
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_flag <= 1'b0;
            ovf_hold      <= 1'b0;
            compare_flag  <= 1'b0;
        end else if (clk_en_in) begin
            if (overflow) begin
                overflow_flag <= 1'b1;
                ovf_hold      <= 1'b1;
            end else begin
                if (tick) begin
                    ovf_hold <= 1'b0;
                end
                if (tcs_rd & ~ovf_hold) begin
                    overflow_flag <= 1'b0;
                end
            end
            if (cmp_match) begin
                compare_flag <= 1'b1;
            end else if (pcs_rd) begin
                compare_flag <= 1'b0;
            end
        end
    end

    // Registered outputs
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_output_out <= 1'b0;
            pwm_oe_out     <= 1'b0;
            ovf_irq_out    <= 1'b0;
            cmp_irq_out    <= 1'b0;
            wake_wait_out  <= 1'b0;
            wake_ahalt_out <= 1'b0;
        end else if (clk_en_in) begin
            pwm_output_out <= pwm_pin_enable & (pwm_raw ^ polarity_invert);
            pwm_oe_out     <= pwm_pin_enable;
            ovf_irq_out    <= overflow_flag & overflow_irq_enable;
            cmp_irq_out    <= compare_flag & compare_irq_enable;
            wake_wait_out  <= (power_mode == `ARTPWM_PM_WAIT) &
                              ((overflow_flag & overflow_irq_enable) |
                               (compare_flag & compare_irq_enable));
            wake_ahalt_out <= (power_mode == `ARTPWM_PM_AHALT) & ahalt_run & overflow_flag;
        end
    end

endmodule // artpwm_timer

// ### tb/artpwm_timer_asserts.sv
`timescale 1ns/1ps
module artpwm_timer_asserts (
    input wire        clk_sys_in,
    input wire        rst_n_in,
    input wire        clk_en_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        pwm_output_out,
    input wire        pwm_oe_out,
    input wire        ovf_irq_out,
    input wire        cmp_irq_out,
    input wire        wake_wait_out,
    input wire        wake_ahalt_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    a_pin_release: assert property (!pwm_oe_out |-> !pwm_output_out)
        else $error("pwm level while pin released");
    a_upper_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_wake_wait_src: assert property (wake_wait_out |-> (ovf_irq_out || cmp_irq_out))
        else $error("wait wake without pending request");
    a_wake_ahalt_src: assert property (wake_ahalt_out |-> ovf_irq_out)
        else $error("active-halt wake without overflow request");
    a_wake_excl: assert property (!(wake_wait_out && wake_ahalt_out))
        else $error("both wake outputs high");
    a_reset_quiet: assert property ($rose(rst_n_in) |->
        avs_waitrequest_out && !pwm_oe_out && !pwm_output_out && !ovf_irq_out && !cmp_irq_out)
        else $error("outputs not at reset level");
    a_answer_bound: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in
        |-> ##[0:2] !avs_waitrequest_out)
        else $error("bus answer late");
    a_done_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low two cycles");
    a_freeze_hold: assert property (!clk_en_in |=> $stable(pwm_output_out) && $stable(ovf_irq_out))
        else $error("outputs moved while frozen");
    cover property (!avs_waitrequest_out && avs_read_in);
    cover property ($rose(pwm_output_out));
    cover property ($rose(cmp_irq_out));
    cover property ($rose(wake_ahalt_out));
endmodule // artpwm_timer_asserts

bind artpwm_timer artpwm_timer_asserts u_chk (.*);

// ### tb/artpwm_timer_tb.sv
`timescale 1ns/1ps
module artpwm_timer_tb;
    logic        clk_sys_in = 0, rst_n_in = 0, clk_en_in = 1, tbase_tick_in = 0;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 0, avs_write_in = 0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'h0;
    wire  [31:0] avs_readdata_out;
    wire         avs_waitrequest_out, pwm_output_out, pwm_oe_out, ovf_irq_out;
    wire         cmp_irq_out, wake_wait_out, wake_ahalt_out;
    int          failures = 0, samples_checked = 0, n, hi, per;
    logic [7:0]  rdv, sv;
    logic [11:0] rl, dt;
    logic [7:0]  regs [10] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18, 8'h20};

    artpwm_timer DUT (.*);
    initial forever #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) tbase_tick_in <= ~tbase_tick_in;

    task automatic bus(input bit wr, input [7:0] idx, input [7:0] wd);
        @(posedge clk_sys_in);
        avs_address_in <= {idx[5:0], 2'b00};
        avs_writedata_in <= {24'h0, wd};
        avs_byteenable_in <= 4'h1;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (avs_waitrequest_out !== 1'b0 && n < 20);
        if (n >= 20) failures++;
        rdv = avs_readdata_out[7:0];
        avs_write_in <= 0;
        avs_read_in <= 0;
    endtask
    task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
        samples_checked++;
        if (got !== ex) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic rchk(input string nm, input [7:0] idx, input [7:0] ex);
        bus(0, idx, 8'h00);
        chk(nm, {4'h0, ex}, {4'h0, rdv});
    endtask
    task automatic until_hi(input bit sel, input int lim);
        n = 0;
        while ((sel ? wake_ahalt_out : ovf_irq_out) !== 1'b1 && n < lim) begin @(posedge clk_sys_in); n++; end
    endtask
    // High time and period between two rising edges
    task automatic measure;
        n = 0;
        while (pwm_output_out !== 1'b0 && n < 5000) begin @(posedge clk_sys_in); n++; end
        while (pwm_output_out !== 1'b1 && n < 5000) begin @(posedge clk_sys_in); n++; end
        hi = 0;
        while (pwm_output_out === 1'b1 && n < 5000) begin hi++; @(posedge clk_sys_in); n++; end
        per = hi;
        while (pwm_output_out === 1'b0 && n < 5000) begin per++; @(posedge clk_sys_in); n++; end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys_in);
        failures++;
        results;
    end

    initial begin
        void'($urandom(18));
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1;
        bus(1, 8'h20, 8'h5a);
        foreach (regs[i]) rchk("reset", regs[i], 8'h00);
        bus(1, 8'h10, 8'hff);
        rchk("reload_high", 8'h10, 8'h0f);
        bus(1, 8'h0d, 8'he7);
        rchk("tcs_bits", 8'h0d, 8'h03);
        rchk("count_off", 8'h0f, 8'h00);
        bus(1, 8'h13, 8'hfe);
        rchk("pcs_bits", 8'h13, 8'h02);
        $display("test registers done");
        rl = 12'h800 | 12'($urandom_range(127));
        bus(1, 8'h10, {4'h0, rl[11:8]});
        bus(1, 8'h11, rl[7:0]);
        bus(1, 8'h1f, 8'h01);
        bus(1, 8'h0d, 8'h12);
        until_hi(1'b0, 5000);
        @(posedge clk_sys_in);
        chk("wake_wait", 12'h1, {11'h0, wake_wait_out});
        rchk("count_high", 8'h0e, {4'h0, rl[11:8]});
        rchk("tcs_ovf", 8'h0d, 8'h16);
        rchk("tcs_clear", 8'h0d, 8'h12);
        @(posedge clk_sys_in);
        chk("ovf_irq", 12'h0, {11'h0, ovf_irq_out});
        bus(1, 8'h1f, 8'h03);
        bus(0, 8'h0f, 8'h00);
        sv = rdv;
        repeat (20) @(posedge clk_sys_in);
        rchk("halt", 8'h0f, sv);
        bus(1, 8'h1f, 8'h04);
        bus(0, 8'h0f, 8'h00);
        sv = rdv;
        repeat (60) @(posedge clk_sys_in);
        bus(0, 8'h0f, 8'h00);
        chk("slow", 12'h1, {11'h0, 8'(rdv - sv) inside {8'd1, 8'd2}});
        $display("test overflow done");
        bus(1, 8'h1f, 8'h00);
        rl = 12'hf00 | 12'($urandom_range(63));
        bus(1, 8'h10, {4'h0, rl[11:8]});
        bus(1, 8'h11, rl[7:0]);
        bus(1, 8'h12, 8'h01);
        for (int k = 0; k < 2; k++) begin
            dt = rl + (k ? 12'($urandom_range(4094 - rl, 2)) : 12'h1);
            bus(1, 8'h17, {4'h0, dt[11:8]});
            bus(1, 8'h18, dt[7:0]);
            bus(1, 8'h13, {6'h0, k[0], 1'b0});
            measure;
            measure;
            chk("period", 12'(4096 - rl), 12'(per));
            chk("high", k ? 12'(4095 - dt) : 12'(dt - rl + 1), 12'(hi));
        end
        chk("pin_oe", 12'h1, {11'h0, pwm_oe_out});
        $display("test pwm done");
        bus(1, 8'h12, 8'h00);
        bus(1, 8'h13, 8'h00);
        bus(1, 8'h0d, 8'h11);
        bus(1, 8'h17, 8'h00);
        bus(1, 8'h18, 8'h00);
        bus(0, 8'h13, 8'h00);
        repeat (300) @(posedge clk_sys_in);
        rchk("zero_duty", 8'h13, 8'h00);
        chk("pin_off", 12'h0, {11'h0, pwm_oe_out});
        dt = rl + 12'($urandom_range(4094 - rl, 1));
        bus(1, 8'h17, {4'h0, dt[11:8]});
        repeat (300) @(posedge clk_sys_in);
        rchk("locked", 8'h13, 8'h00);
        bus(1, 8'h18, dt[7:0]);
        repeat (300) @(posedge clk_sys_in);
        chk("cmp_irq", 12'h1, {11'h0, cmp_irq_out});
        rchk("cmp_flag", 8'h13, 8'h01);
        rchk("cmp_clear", 8'h13, 8'h00);
        $display("test compare done");
        bus(1, 8'h10, 8'h0f);
        bus(1, 8'h11, 8'hfe);
        bus(1, 8'h0d, 8'h0a);
        bus(0, 8'h0d, 8'h00);
        bus(1, 8'h1f, 8'h02);
        until_hi(1'b1, 1000);
        chk("wake_ahalt", 12'h1, {11'h0, wake_ahalt_out});
        bus(1, 8'h0d, 8'h12);
        bus(0, 8'h0f, 8'h00);
        sv = rdv;
        repeat (20) @(posedge clk_sys_in);
        rchk("ahalt_stop", 8'h0f, sv);
        clk_en_in <= 0;
        repeat (8) @(posedge clk_sys_in);
        clk_en_in <= 1;
        $display("test power done");
        results;
    end
endmodule // artpwm_timer_tb
